// [hw/sdp_pkg.sv]
// Shared constants of the stacked-die select port.
// Assumes a single 250 MHz clock; host pins arrive synchronous to it.
package sdp_pkg;

	// ----------------------------------------
	// Bus widths and die counts
	// ----------------------------------------
	localparam int DATA_W       = 16;
	localparam int ADDR_W       = 26;
	localparam int FLASH_DIES   = 3;
	localparam int PSRAM_DIES   = 2;

	// ----------------------------------------
	// Top address bit per flash density, and lowest reserved address bit
	// ----------------------------------------
	localparam int TOP_BIT_128M = 22;
	localparam int TOP_BIT_64M  = 21;
	localparam int TOP_BIT_32M  = 20;
	localparam int RESERVED_LO  = 24;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 26'h0000000;

endpackage

// [hw/sdp_flash_die_port.sv]
// One flash die: select, output buffer request and write capture.
// Assumes pins already sampled by the parent, one sample per enabled clock.
`timescale 1ns/10ps
module sdp_flash_die_port #(
	parameter int TOP_BIT = sdp_pkg::TOP_BIT_128M
) (
	// Clock and reset
	input  wire logic                        clock,
	input  wire logic                        reset_n,
	input  wire logic                        clock_enable,
	// Sampled host controls
	input  wire logic                        enable_n,
	input  wire logic                        output_enable_n,
	input  wire logic                        write_enable_n,
	input  wire logic [sdp_pkg::ADDR_W-1:0]  address,
	input  wire logic [sdp_pkg::DATA_W-1:0]  data_in,
	// Die side
	output logic                             drive_req,
	output logic                             active,
	output logic                             write_strobe,
	output logic [sdp_pkg::ADDR_W-1:0]       write_address,
	output logic [sdp_pkg::DATA_W-1:0]       write_data
);
	import sdp_pkg::*;

	logic                prev_we_n;
	logic                prev_en_n;
	logic                next_active;
	logic                next_strobe;
	logic [ADDR_W-1:0]   next_address;
	logic [DATA_W-1:0]   next_data;
	logic [ADDR_W-1:0]   word_mask;

	// Reads are refused while a write pulse is low
	assign drive_req = !enable_n && !output_enable_n && write_enable_n; // R13 R17
	// Word address: bits above the top bit, reserved ones included, are dropped
	assign word_mask = ADDR_W'((27'h1 << (TOP_BIT + 1)) - 27'h1); // R1 R2 R3

	always_comb begin
		next_active  = !enable_n; // R6 R7
		next_strobe  = 1'b0;
		next_address = write_address;
		next_data    = write_data;
		// Capture on the rising edge of the write enable while selected
		if (!prev_we_n && write_enable_n && !prev_en_n) begin // R16
			next_strobe  = 1'b1;
			next_address = address & word_mask;
			next_data    = data_in; // R4
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			prev_we_n     <= 1'b1;
			prev_en_n     <= 1'b1;
			active        <= 1'b0;
			write_strobe  <= 1'b0;
			write_address <= ADDR_RESET;
			write_data    <= DATA_RESET;
		end else if (clock_enable) begin
			prev_we_n     <= write_enable_n;
			prev_en_n     <= enable_n;
			active        <= next_active;
			write_strobe  <= next_strobe;
			write_address <= next_address;
			write_data    <= next_data;
		end
	end

endmodule // sdp_flash_die_port

// [hw/sdp_ram_port.sv]
// SRAM and PSRAM die selection and RAM output buffer request.
// Assumes pins already sampled by the parent.
`timescale 1ns/10ps
module sdp_ram_port (
	// Clock and reset
	input  wire logic                            clock,
	input  wire logic                            reset_n,
	input  wire logic                            clock_enable,
	// Sampled host controls
	input  wire logic                            sram_select_low_n,
	input  wire logic                            sram_select_high,
	input  wire logic [sdp_pkg::PSRAM_DIES-1:0]  psram_select_n,
	input  wire logic                            ram_output_enable_n,
	// Die side
	output logic                                 sram_drive_req,
	output logic [sdp_pkg::PSRAM_DIES-1:0]       psram_drive_req,
	output logic                                 sram_active,
	output logic [sdp_pkg::PSRAM_DIES-1:0]       psram_active
);
	import sdp_pkg::*;

	logic                   sram_sel;
	logic                   next_sram_active;
	logic [PSRAM_DIES-1:0]  next_psram_active;

	// Either select deasserted deselects the SRAM
	assign sram_sel        = !sram_select_low_n && sram_select_high; // R9 R10
	assign sram_drive_req  = sram_sel && !ram_output_enable_n; // R15 R17
	assign psram_drive_req = ~psram_select_n & {PSRAM_DIES{!ram_output_enable_n}}; // R15 R17

	always_comb begin
		next_sram_active  = sram_sel; // R9 R10
		next_psram_active = ~psram_select_n; // R11 R12
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sram_active  <= 1'b0;
			psram_active <= '0;
		end else if (clock_enable) begin
			sram_active  <= next_sram_active;
			psram_active <= next_psram_active;
		end
	end

endmodule // sdp_ram_port

// [hw/sdp_select_port.sv]
// Die-select and bus-control front end of a stacked memory package.
// Assumes host pins synchronous to clock; the tristate wire is resolved outside.
`timescale 1ns/10ps

// Functional notes
// R1: Flash top address bit follows die density.
// R2: Address bit zero selects 16-bit words.
// R3: Two reserved high address bits are ignored.
// R4: Data bus takes writes, returns read data.
// R5: Data floats when deselected or buffers off.
// R6: Low flash enable activates that die.
// R7: High flash enable: standby, data, wait float.
// R8: Three flash enables map to dies 1-3.
// R9: SRAM selected by low and high selects.
// R10: SRAM deselected into standby otherwise.
// R11: Two PSRAM selects map to dies 1-2.
// R12: PSRAM select activates die, else standby.
// R13: Flash output enable gates flash buffers.
// R14: Second flash output enable serves dies 2-3.
// R15: RAM output enable gates RAM buffers.
// R16: Flash write captured on write-enable rising edge.
// R17: Die drives only when selected and enabled.
module sdp_select_port #(
	parameter int DIE1_TOP_BIT = sdp_pkg::TOP_BIT_128M,
	parameter int DIE2_TOP_BIT = sdp_pkg::TOP_BIT_128M,
	parameter int DIE3_TOP_BIT = sdp_pkg::TOP_BIT_128M
) (
	// Clock and reset
	input  wire logic                                            clock,
	input  wire logic                                            reset_n,
	input  wire logic                                            clock_enable,
	// Host address and data
	input  wire logic [sdp_pkg::ADDR_W-1:0]                      address,
	input  wire logic [sdp_pkg::DATA_W-1:0]                      data_in,
	output logic      [sdp_pkg::DATA_W-1:0]                      data_out,
	output logic                                                 data_oe_n,
	// Host flash controls
	input  wire logic                                            flash_die1_enable_n,
	input  wire logic                                            flash_die2_enable_n,
	input  wire logic                                            flash_die3_enable_n,
	input  wire logic                                            flash_die1_output_enable_n,
	input  wire logic                                            flash_upper_dies_output_enable_n,
	input  wire logic                                            flash_write_enable_n,
	output logic                                                 wait_out,
	output logic                                                 wait_oe_n,
	// Host RAM controls
	input  wire logic                                            sram_select_low_n,
	input  wire logic                                            sram_select_high,
	input  wire logic                                            psram_die1_select_n,
	input  wire logic                                            psram_die2_select_n,
	input  wire logic                                            ram_output_enable_n,
	// Die read side
	input  wire logic [sdp_pkg::FLASH_DIES-1:0][sdp_pkg::DATA_W-1:0] flash_read_data,
	input  wire logic [sdp_pkg::FLASH_DIES-1:0]                  flash_wait_level,
	input  wire logic [sdp_pkg::DATA_W-1:0]                      sram_read_data,
	input  wire logic [sdp_pkg::PSRAM_DIES-1:0][sdp_pkg::DATA_W-1:0] psram_read_data,
	// Die status and write side
	output logic      [sdp_pkg::FLASH_DIES-1:0]                  flash_die_active,
	output logic                                                 sram_active,
	output logic      [sdp_pkg::PSRAM_DIES-1:0]                  psram_active,
	output logic      [sdp_pkg::FLASH_DIES-1:0]                  flash_write_strobe,
	output logic      [sdp_pkg::FLASH_DIES-1:0][sdp_pkg::ADDR_W-1:0] flash_write_address,
	output logic      [sdp_pkg::FLASH_DIES-1:0][sdp_pkg::DATA_W-1:0] flash_write_data
);
	import sdp_pkg::*;

	localparam int DRIVERS = FLASH_DIES + 1 + PSRAM_DIES;

	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------
	logic [ADDR_W-1:0]      pin_address;
	logic [DATA_W-1:0]      pin_data;
	logic [FLASH_DIES-1:0]  pin_flash_en_n;
	logic [1:0]             pin_flash_oe_n;
	logic                   pin_we_n;
	logic                   pin_sram_low_n;
	logic                   pin_sram_high;
	logic [PSRAM_DIES-1:0]  pin_psram_n;
	logic                   pin_ram_oe_n;

	logic [ADDR_W-1:0]      next_pin_address;
	logic [DATA_W-1:0]      next_pin_data;
	logic [FLASH_DIES-1:0]  next_pin_flash_en_n;
	logic [1:0]             next_pin_flash_oe_n;
	logic                   next_pin_we_n;
	logic                   next_pin_sram_low_n;
	logic                   next_pin_sram_high;
	logic [PSRAM_DIES-1:0]  next_pin_psram_n;
	logic                   next_pin_ram_oe_n;

	always_comb begin
		next_pin_address    = address; // R2
		next_pin_data       = data_in;
		next_pin_flash_en_n = {flash_die3_enable_n, flash_die2_enable_n, flash_die1_enable_n}; // R8
		next_pin_flash_oe_n = {flash_upper_dies_output_enable_n, flash_die1_output_enable_n};
		next_pin_we_n       = flash_write_enable_n;
		next_pin_sram_low_n = sram_select_low_n;
		next_pin_sram_high  = sram_select_high;
		next_pin_psram_n    = {psram_die2_select_n, psram_die1_select_n}; // R11
		next_pin_ram_oe_n   = ram_output_enable_n;
	end

	// Idle levels at reset keep every die deselected
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pin_address    <= ADDR_RESET;
			pin_data       <= DATA_RESET;
			pin_flash_en_n <= '1;
			pin_flash_oe_n <= '1;
			pin_we_n       <= 1'b1;
			pin_sram_low_n <= 1'b1;
			pin_sram_high  <= 1'b0;
			pin_psram_n    <= '1;
			pin_ram_oe_n   <= 1'b1;
		end else if (clock_enable) begin
			pin_address    <= next_pin_address;
			pin_data       <= next_pin_data;
			pin_flash_en_n <= next_pin_flash_en_n;
			pin_flash_oe_n <= next_pin_flash_oe_n;
			pin_we_n       <= next_pin_we_n;
			pin_sram_low_n <= next_pin_sram_low_n;
			pin_sram_high  <= next_pin_sram_high;
			pin_psram_n    <= next_pin_psram_n;
			pin_ram_oe_n   <= next_pin_ram_oe_n;
		end
	end

	// ----------------------------------------
	// Die ports
	// ----------------------------------------
	logic [FLASH_DIES-1:0]  flash_drive_req;
	logic                   sram_drive_req;
	logic [PSRAM_DIES-1:0]  psram_drive_req;

	localparam int TOP_BITS [FLASH_DIES] = '{DIE1_TOP_BIT, DIE2_TOP_BIT, DIE3_TOP_BIT};

	for (genvar i = 0; i < FLASH_DIES; i++) begin : g_flash
		sdp_flash_die_port #(
			.TOP_BIT (TOP_BITS[i])
		) u_die (
			.clock           (clock),
			.reset_n         (reset_n),
			.clock_enable    (clock_enable),
			.enable_n        (pin_flash_en_n[i]), // R8
			.output_enable_n (pin_flash_oe_n[(i == 0) ? 0 : 1]), // R14
			.write_enable_n  (pin_we_n),
			.address         (pin_address),
			.data_in         (pin_data),
			.drive_req       (flash_drive_req[i]),
			.active          (flash_die_active[i]),
			.write_strobe    (flash_write_strobe[i]),
			.write_address   (flash_write_address[i]),
			.write_data      (flash_write_data[i])
		);
	end

	sdp_ram_port u_ram (
		.clock               (clock),
		.reset_n             (reset_n),
		.clock_enable        (clock_enable),
		.sram_select_low_n   (pin_sram_low_n),
		.sram_select_high    (pin_sram_high),
		.psram_select_n      (pin_psram_n),
		.ram_output_enable_n (pin_ram_oe_n),
		.sram_drive_req      (sram_drive_req),
		.psram_drive_req     (psram_drive_req),
		.sram_active         (sram_active),
		.psram_active        (psram_active)
	);

	// ----------------------------------------
	// Data and wait outputs
	// ----------------------------------------
	// Lowest index wins; the host is expected to select one reader at a time
	function automatic logic [2:0] first_set(input logic [DRIVERS-1:0] req);
		logic [2:0] idx;
		idx = 3'h0;
		for (int k = DRIVERS - 1; k >= 0; k--) begin
			if (req[k]) begin
				idx = 3'(k);
			end
		end
		return idx;
	endfunction

	logic [DRIVERS-1:0]  drive_req;
	logic [DATA_W-1:0]   next_data_out;
	logic                next_data_oe_n;
	logic                next_wait_out;
	logic                next_wait_oe_n;
	logic [2:0]          drv_idx;
	logic [1:0]          wait_idx;

	assign drive_req = {psram_drive_req, sram_drive_req, flash_drive_req}; // R17

	always_comb begin
		drv_idx        = first_set(drive_req);
		wait_idx       = 2'(first_set({3'h0, ~pin_flash_en_n}));
		next_data_oe_n = !(|drive_req); // R5 R13 R15
		next_data_out  = data_out;
		if (|drive_req) begin
			unique case (drv_idx)
				3'h0, 3'h1, 3'h2: next_data_out = flash_read_data[drv_idx[1:0]]; // R4
				3'h3:             next_data_out = sram_read_data;
				default:          next_data_out = psram_read_data[drv_idx == 3'h5];
			endcase
		end
		// Wait is gated by the enables only, not by output enables
		next_wait_oe_n = &pin_flash_en_n; // R7
		next_wait_out  = next_wait_oe_n ? 1'b0 : flash_wait_level[wait_idx];
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			data_out  <= DATA_RESET;
			data_oe_n <= 1'b1;
			wait_out  <= 1'b0;
			wait_oe_n <= 1'b1;
		end else if (clock_enable) begin
			data_out  <= next_data_out;
			data_oe_n <= next_data_oe_n;
			wait_out  <= next_wait_out;
			wait_oe_n <= next_wait_oe_n;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	float_desel_a: assert property (!data_oe_n |-> (|flash_die_active) || sram_active || (|psram_active)) // R5
		else $error("data driven with no die selected");
	flash_sel_a: assert property (clock_enable && pin_flash_en_n == 3'b110 |=> flash_die_active == 3'b001) // R6
		else $error("flash die one not activated");
	flash_desel_a: assert property (clock_enable && &pin_flash_en_n && pin_ram_oe_n |=> data_oe_n && wait_oe_n) // R7
		else $error("deselected flash still drives");
	upper_oe_a: assert property (clock_enable && pin_flash_en_n == 3'b011 && !pin_flash_oe_n[1] && pin_we_n // R14
		|=> !data_oe_n && data_out == $past(flash_read_data[2]))
		else $error("third die not driven by upper output enable");
	flash_oe_a: assert property (clock_enable && &pin_flash_oe_n && pin_ram_oe_n |=> data_oe_n) // R13
		else $error("flash buffers on with output enable high");
	sram_sel_a: assert property (clock_enable // R9
		|=> sram_active == (!$past(pin_sram_low_n) && $past(pin_sram_high)))
		else $error("sram select decode wrong");
	psram_sel_a: assert property (clock_enable |=> psram_active == ~$past(pin_psram_n)) // R12
		else $error("psram select decode wrong");
	ram_oe_a: assert property (clock_enable && &pin_flash_en_n && !pin_ram_oe_n && !pin_psram_n[1] // R15
		&& pin_psram_n[0] && pin_sram_high == 1'b0 |=> !data_oe_n && data_out == $past(psram_read_data[1]))
		else $error("psram two not driven");
	die_map_a: assert property (clock_enable |=> flash_die_active == ~$past(pin_flash_en_n)) // R8
		else $error("flash enable to die mapping wrong");
	sram_read_a: assert property (clock_enable && &pin_flash_en_n && !pin_sram_low_n && pin_sram_high // R4
		&& !pin_ram_oe_n |=> !data_oe_n && data_out == $past(sram_read_data))
		else $error("sram read data not driven");
	psram_one_a: assert property (clock_enable && &pin_flash_en_n && !pin_ram_oe_n && pin_psram_n == 2'b10 // R11
		&& !pin_sram_high |=> !data_oe_n && data_out == $past(psram_read_data[0]))
		else $error("psram one not driven");
	sram_desel_a: assert property (clock_enable && &pin_flash_en_n && &pin_psram_n // R10
		&& (pin_sram_low_n || !pin_sram_high) |=> data_oe_n)
		else $error("deselected sram still drives");
	wait_level_a: assert property (clock_enable && pin_flash_en_n == 3'b101 // R7
		|=> !wait_oe_n && wait_out == $past(flash_wait_level[1]))
		else $error("wait of die two not passed");

	// ----------------------------------------
	// Write capture checks
	// ----------------------------------------
	write_edge_a: assert property (clock_enable && !pin_we_n && !pin_flash_en_n[0] ##1 // R16
		clock_enable && pin_we_n |=> flash_write_strobe[0] && flash_write_data[0] == $past(pin_data))
		else $error("write not captured on rising edge");
	addr_mask_a: assert property (flash_write_strobe[0] // R1
		|-> flash_write_address[0][ADDR_W-1:DIE1_TOP_BIT+1] == '0)
		else $error("address bits above top bit kept");
	strobe_pulse_a: assert property (flash_write_strobe[0] && clock_enable |=> !flash_write_strobe[0]) // R16
		else $error("write strobe longer than one cycle");
	die2_mask_a: assert property (flash_write_strobe[1] // R1
		|-> flash_write_address[1][ADDR_W-1:DIE2_TOP_BIT+1] == '0)
		else $error("die two address bits above top bit kept");
	die3_mask_a: assert property (flash_write_strobe[2] // R1
		|-> flash_write_address[2][ADDR_W-1:DIE3_TOP_BIT+1] == '0)
		else $error("die three address bits above top bit kept");
	// Reset value included, so no stored address ever carries them
	reserved_bits_a: assert property (flash_write_address[0][ADDR_W-1:RESERVED_LO] == '0 // R3
		&& flash_write_address[1][ADDR_W-1:RESERVED_LO] == '0
		&& flash_write_address[2][ADDR_W-1:RESERVED_LO] == '0)
		else $error("reserved address bits stored");
	word_addr_a: assert property (clock_enable && !pin_we_n && !pin_flash_en_n[0] // R2
		##1 clock_enable && pin_we_n
		|=> flash_write_address[0][DIE1_TOP_BIT:0] == $past(pin_address[DIE1_TOP_BIT:0]))
		else $error("word address bits not kept");
	write_float_a: assert property (clock_enable && !pin_we_n && pin_ram_oe_n |=> data_oe_n) // R4
		else $error("data driven during a write pulse");

	// ----------------------------------------
	// Coverage
	// ----------------------------------------
	flash_read_c: cover property (!data_oe_n && flash_die_active[0]);
	flash_write_c: cover property (flash_write_strobe[1]);
	sram_read_c: cover property (!data_oe_n && sram_active);
	psram_read_c: cover property (!data_oe_n && psram_active[1]);
	wait_c: cover property (!wait_oe_n && wait_out);

endmodule // sdp_select_port

// [test/sdp_host_model.sv]
// Host memory controller model that drives the select port's host pins.
// Assumes the bench calls apply and write_word; the data bus has no pull resistor.
`timescale 1ns/10ps
module sdp_host_model (
	// Clock and returned data
	input  wire logic                        clock,
	input  wire logic [sdp_pkg::DATA_W-1:0]  data_out,
	input  wire logic                        data_oe_n,
	// Host pins
	output logic      [10:0]                 ctl,
	output logic      [sdp_pkg::ADDR_W-1:0]  address,
	output logic      [sdp_pkg::DATA_W-1:0]  data_in
);
	import sdp_pkg::*;
	logic [DATA_W-1:0]  host_data;
	logic [DATA_W-1:0]  last_level;
	logic               host_drv;
	initial begin
		ctl = 11'h7f7;
		address = 26'h0000000;
		host_data = 16'h0000;
		host_drv = 1'b0;
		last_level = 16'h0000;
	end
	// Floating bus has no pull, so it toggles rather than keep a stale copy
	always_comb data_in = host_drv ? host_data : (data_oe_n ? ~last_level : data_out);
	always @(posedge clock) last_level <= data_in;
	task automatic apply(input logic [10:0] c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic drv);
		@(posedge clock);
		ctl <= c;
		address <= a;
		host_data <= d;
		host_drv <= drv;
	endtask
	// Strobe low with the die enabled, then raise it with address and data held
	task automatic write_word(input logic [10:0] sel, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		apply(11'h7f7 ^ sel ^ 11'h020, a, d, 1'b1);
		apply(11'h7f7 ^ sel, a, d, 1'b1);
	endtask
endmodule // sdp_host_model

// [test/tb.sv]
// Self-checking bench for the stacked-die select port.
// Assumes the host model in sdp_host_model; die read data are fixed per die.
`timescale 1ns/10ps
module tb;
	import sdp_pkg::*;
	typedef struct packed {
		logic [10:0] ctl;
		logic [2:0]  fa;
		logic        sa;
		logic [1:0]  pa;
		logic        doe;
		logic [15:0] dout;
		logic        woe;
		logic        wt;
	} sdp_row_t;
	// ----------------------------------------
	// Pin masks, in host model ctl order
	// ----------------------------------------
	localparam logic [10:0] IDLE = 11'h7f7, F1 = 11'h400, F2 = 11'h200, F3 = 11'h100, OE1 = 11'h080;
	localparam logic [10:0] OEU = 11'h040, WE = 11'h020, SL = 11'h010, SH = 11'h008, P1 = 11'h004;
	localparam logic [10:0] P2 = 11'h002, ROE = 11'h001;
	logic                                 clock = 1'b0, reset_n = 1'b0, clock_enable = 1'b1;
	logic [10:0]                          ctl;
	logic [ADDR_W-1:0]                    address;
	logic [DATA_W-1:0]                    data_in, data_out, sram_read_data;
	logic                                 data_oe_n, wait_out, wait_oe_n, sram_active;
	logic [FLASH_DIES-1:0][DATA_W-1:0]    flash_read_data, flash_write_data;
	logic [FLASH_DIES-1:0]                flash_wait_level, flash_die_active, flash_write_strobe;
	logic [PSRAM_DIES-1:0][DATA_W-1:0]    psram_read_data;
	logic [PSRAM_DIES-1:0]                psram_active;
	logic [FLASH_DIES-1:0][ADDR_W-1:0]    flash_write_address;
	int                                   fail_count = 0, tests_run = 0;
	sdp_row_t                             rows [0:16];
	always #2 clock = ~clock;
	initial begin
		flash_read_data = {16'ha303, 16'ha202, 16'ha101};
		flash_wait_level = 3'h5;
		sram_read_data = 16'hb404;
		psram_read_data = {16'hc606, 16'hc505};
	end
	sdp_host_model sdp_host_model_inst (.clock(clock), .data_out(data_out), .data_oe_n(data_oe_n), .ctl(ctl),
		.address(address), .data_in(data_in));
	sdp_select_port #(.DIE1_TOP_BIT(TOP_BIT_128M), .DIE2_TOP_BIT(TOP_BIT_64M), .DIE3_TOP_BIT(TOP_BIT_32M))
	sdp_select_port_inst (.clock(clock), .reset_n(reset_n), .clock_enable(clock_enable), .address(address),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .flash_die1_enable_n(ctl[10]),
		.flash_die2_enable_n(ctl[9]), .flash_die3_enable_n(ctl[8]), .flash_die1_output_enable_n(ctl[7]),
		.flash_upper_dies_output_enable_n(ctl[6]), .flash_write_enable_n(ctl[5]), .wait_out(wait_out),
		.wait_oe_n(wait_oe_n), .sram_select_low_n(ctl[4]), .sram_select_high(ctl[3]),
		.psram_die1_select_n(ctl[2]), .psram_die2_select_n(ctl[1]), .ram_output_enable_n(ctl[0]),
		.flash_read_data(flash_read_data), .flash_wait_level(flash_wait_level), .sram_read_data(sram_read_data),
		.psram_read_data(psram_read_data), .flash_die_active(flash_die_active), .sram_active(sram_active),
		.psram_active(psram_active), .flash_write_strobe(flash_write_strobe),
		.flash_write_address(flash_write_address), .flash_write_data(flash_write_data));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		if (fail_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Pins seen one edge later, outputs one edge after that
	task automatic settle;
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic write_die(input int die, input logic [10:0] sel, input logic [25:0] a, input logic [15:0] d,
		input logic [25:0] exp_a);
		int n;
		n = 0;
		sdp_host_model_inst.write_word(sel, a, d);
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (n < 6 && flash_write_strobe[die] !== 1'b1);
		if (n >= 6) begin
			fail_count++;
			report_and_stop();
		end
		check("strobe latency", n, 2);
		check("flash_write_strobe", flash_write_strobe, 3'h1 << die);
		check("flash_write_address", flash_write_address[die], exp_a);
		check("flash_write_data", flash_write_data[die], d);
		@(posedge clock);
		#1;
		check("strobe width", flash_write_strobe, 3'h0);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rows = '{{IDLE, 3'h0, 1'h0, 2'h0, 1'h1, 16'h0000, 1'h1, 1'h0},
			{IDLE ^ F1 ^ OE1, 3'h1, 1'h0, 2'h0, 1'h0, 16'ha101, 1'h0, 1'h1},
			{IDLE ^ F2 ^ OEU, 3'h2, 1'h0, 2'h0, 1'h0, 16'ha202, 1'h0, 1'h0},
			{IDLE ^ F3 ^ OEU, 3'h4, 1'h0, 2'h0, 1'h0, 16'ha303, 1'h0, 1'h1},
			{IDLE ^ F2 ^ OE1, 3'h2, 1'h0, 2'h0, 1'h1, 16'h0000, 1'h0, 1'h0},
			{IDLE ^ F3 ^ OE1, 3'h4, 1'h0, 2'h0, 1'h1, 16'h0000, 1'h0, 1'h1},
			{IDLE ^ F1 ^ OEU, 3'h1, 1'h0, 2'h0, 1'h1, 16'h0000, 1'h0, 1'h1},
			{IDLE ^ OE1 ^ OEU, 3'h0, 1'h0, 2'h0, 1'h1, 16'h0000, 1'h1, 1'h0},
			{IDLE ^ SL ^ SH ^ ROE, 3'h0, 1'h1, 2'h0, 1'h0, 16'hb404, 1'h1, 1'h0},
			{IDLE ^ SL ^ ROE, 3'h0, 1'h0, 2'h0, 1'h1, 16'h0000, 1'h1, 1'h0},
			{IDLE ^ SH ^ ROE, 3'h0, 1'h0, 2'h0, 1'h1, 16'h0000, 1'h1, 1'h0},
			{IDLE ^ P1 ^ ROE, 3'h0, 1'h0, 2'h1, 1'h0, 16'hc505, 1'h1, 1'h0},
			{IDLE ^ P2 ^ ROE, 3'h0, 1'h0, 2'h2, 1'h0, 16'hc606, 1'h1, 1'h0},
			{IDLE ^ P1 ^ P2 ^ ROE, 3'h0, 1'h0, 2'h3, 1'h0, 16'hc505, 1'h1, 1'h0},
			{IDLE ^ P1, 3'h0, 1'h0, 2'h1, 1'h1, 16'h0000, 1'h1, 1'h0},
			{IDLE ^ F1 ^ OE1 ^ SL ^ SH ^ ROE, 3'h1, 1'h1, 2'h0, 1'h0, 16'ha101, 1'h0, 1'h1},
			{IDLE ^ F1 ^ OE1 ^ WE, 3'h1, 1'h0, 2'h0, 1'h1, 16'h0000, 1'h0, 1'h1}};
		repeat (12) @(posedge clock);
		#1;
		check("reset data_oe_n", data_oe_n, 1'h1);
		check("reset active", {flash_die_active, sram_active, psram_active}, 6'h00);
		check("reset strobe", flash_write_strobe, 3'h0);
		@(posedge clock);
		reset_n <= 1'b1;
		foreach (rows[i]) begin
			sdp_host_model_inst.apply(rows[i].ctl, 26'h0000000, 16'h0000, 1'b0);
			settle();
			check("flash_die_active", flash_die_active, rows[i].fa);
			check("sram_active", sram_active, rows[i].sa);
			check("psram_active", psram_active, rows[i].pa);
			check("data_oe_n", data_oe_n, rows[i].doe);
			if (rows[i].doe === 1'b0) begin
				check("data_out", data_out, rows[i].dout);
			end
			check("wait_oe_n", wait_oe_n, rows[i].woe);
			check("wait_out", wait_out, rows[i].wt);
		end
		// Reset in mid-read, then the read comes back
		sdp_host_model_inst.apply(IDLE ^ F1 ^ OE1, 26'h0000000, 16'h0000, 1'b0);
		settle();
		@(posedge clock);
		reset_n <= 1'b0;
		@(posedge clock);
		#1;
		check("mid reset data_oe_n", {data_oe_n, wait_oe_n, flash_die_active}, 5'h18);
		@(posedge clock);
		reset_n <= 1'b1;
		settle();
		check("after reset read", {data_oe_n, data_out}, 17'h0a101);
		// Frozen while clock_enable is low
		@(posedge clock);
		clock_enable <= 1'b0;
		sdp_host_model_inst.apply(IDLE, 26'h0000000, 16'h0000, 1'b0);
		settle();
		check("frozen active", flash_die_active, 3'h1);
		@(posedge clock);
		clock_enable <= 1'b1;
		settle();
		check("thawed active", {data_oe_n, flash_die_active}, 4'h8);
		// Writes: upper address bits dropped per die density
		write_die(0, F1, 26'h3ffffff, 16'h5a5a, 26'h07fffff);
		write_die(0, F1, 26'h0000001, 16'h0001, 26'h0000001);
		write_die(1, F2, 26'h3ffffff, 16'ha5a5, 26'h03fffff);
		write_die(2, F3, 26'h3ffffff, 16'h3c3c, 26'h01fffff);
		// Strobe rise without any die enabled is not a write
		sdp_host_model_inst.apply(IDLE ^ WE, 26'h0000005, 16'h7777, 1'b1);
		sdp_host_model_inst.apply(IDLE, 26'h0000005, 16'h7777, 1'b1);
		repeat (3) begin
			@(posedge clock);
			#1;
			check("no strobe", flash_write_strobe, 3'h0);
		end
		report_and_stop();
	end
endmodule // tb
